// ==== dv/otd_oscillator_tap_divider_bench.sv ====
module otd_oscillator_tap_divider_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cfg_done_i = 1'b0;
  logic cfg_master_i = 1'b0;
  logic osc_used_i = 1'b0;
  logic [otd_pkg::SEL_W-1:0] tap_a_sel_i = 2'h0;
  logic [otd_pkg::SEL_W-1:0] tap_b_sel_i = 2'h0;
  logic por_tick_o, mem_clear_tick_o, configuration_clock_o;
  logic osc_o, tap_a_o, tap_b_o, osc_running_o;
  int n_mismatch = 0;
  int checks_done = 0;
  otd_oscillator_tap_divider i_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cfg_done_i(cfg_done_i),
    .cfg_master_i(cfg_master_i), .osc_used_i(osc_used_i), .tap_a_sel_i(tap_a_sel_i),
    .tap_b_sel_i(tap_b_sel_i), .por_tick_o(por_tick_o), .mem_clear_tick_o(mem_clear_tick_o),
    .configuration_clock_o(configuration_clock_o), .osc_o(osc_o), .tap_a_o(tap_a_o),
    .tap_b_o(tap_b_o), .osc_running_o(osc_running_o));
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial
  begin
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return configuration_clock_o;
      1: return osc_o;
      2: return tap_a_o;
      3: return tap_b_o;
      default: return por_tick_o;
    endcase
  endfunction
  // count rising edges and longest steady run; ticks are compared pairwise on the way
  task automatic watch(input int k, input int n, output int rises, output int maxrun);
    logic prev;
    int run;
    prev = sig(k);
    rises = 0;
    maxrun = 0;
    run = 1;
    repeat (n)
    begin
      step(1);
      if (por_tick_o !== mem_clear_tick_o) chk("tick pair", 0, 1);
      if (sig(k) === prev) run++;
      else run = 1;
      if (prev === 1'b0 && sig(k) === 1'b1) rises++;
      if (run > maxrun) maxrun = run;
      prev = sig(k);
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    reset_n_i = 1'b0;
    step(4);
    chk("outputs in reset", 0, {por_tick_o, mem_clear_tick_o, configuration_clock_o,
      osc_o, tap_a_o, tap_b_o, osc_running_o});
    reset_n_i = 1'b1;
    $display("test reset done");
  endtask
  task automatic t_config(input logic m);
    int r, mx;
    cfg_done_i = 1'b0;
    cfg_master_i = m;
    step(3);
    watch(4, 100, r, mx);
    chk("por ticks", 40, r);
    watch(0, 100, r, mx);
    chk("cfg clock rises", m ? 40 : 0, r);
    if (m) chk("cfg clock half", 1, mx <= otd_pkg::HALF_MAX_CYC);
    watch(1, 100, r, mx);
    chk("osc before done", 0, r);
    watch(2, 100, r, mx);
    chk("tap before done", 0, r);
    chk("running cfg", 1, osc_running_o);
    $display("test config master=%0d done", m);
  endtask
  task automatic t_user();
    int r, mx;
    cfg_done_i = 1'b1;
    osc_used_i = 1'b1;
    step(3);
    watch(1, 100, r, mx);
    chk("osc rises", 40, r);
    chk("osc half", 1, mx <= otd_pkg::HALF_MAX_CYC);
    watch(4, 100, r, mx);
    chk("por after done", 0, r);
    watch(0, 100, r, mx);
    chk("cfg clock after done", 0, r);
    $display("test user osc done");
  endtask
  // half period of a tap in system cycles: 2**bit oscillator rises at 2.5 cycles each
  task automatic t_tap(input int k, input logic [1:0] sel, input int exp);
    logic prev;
    int n;
    if (k == 2) tap_a_sel_i = sel;
    else tap_b_sel_i = sel;
    step(3);
    prev = sig(k);
    n = 0;
    while (sig(k) === prev && n < 2 * exp + 10)
    begin
      step(1);
      n++;
    end
    prev = sig(k);
    n = 0;
    while (sig(k) === prev && n < 2 * exp + 10)
    begin
      step(1);
      n++;
    end
    chk("tap half period", exp, n);
    $display("test tap sel=%0d done", sel);
  endtask
  task automatic t_stop();
    int r, mx;
    tap_a_sel_i = 2'h0;
    tap_b_sel_i = 2'h3;
    osc_used_i = 1'b0;
    step(3);
    chk("running stopped", 0, osc_running_o);
    watch(1, 100, r, mx);
    chk("osc stopped", 0, r);
    watch(2, 100, r, mx);
    chk("tap stopped", 0, r);
    osc_used_i = 1'b1;
    step(3);
    chk("running again", 1, osc_running_o);
    watch(2, 100, r, mx);
    chk("tap resumes", 1, r >= 2);
    watch(3, 200, r, mx);
    chk("slowest tap low", 0, r);
    $display("test stop done");
  endtask
  // ****************************************************************
  // run
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #3_000_000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    step(0);
    t_reset();
    t_config(1'b1);
    t_config(1'b0);
    t_user();
    t_tap(2, 2'h0, 20);
    t_tap(3, 2'h1, 640);
    t_tap(2, 2'h2, 20480);
    t_tap(3, 2'h0, 20);
    t_stop();
    t_reset();
    tally_and_finish();
  end
endmodule

// ==== logic/otd_div_if.sv ====
interface otd_div_if;
  logic run;
  logic osc_rise;
  logic [otd_pkg::TAP_N-1:0] taps;
  modport src (output run, output osc_rise, input taps);
  modport div (input run, input osc_rise, output taps);
endinterface

// ==== logic/otd_divider.sv ====
module otd_divider (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // oscillator side
  otd_div_if.div dv
);
  logic [otd_pkg::DIV_W-1:0] cnt_ff;
  logic [otd_pkg::DIV_W-1:0] nxt_cnt;
  logic [otd_pkg::TAP_N-1:0] tap_ff;
  logic [otd_pkg::TAP_N-1:0] nxt_tap;

  // ****************************************************************
  // free-running counter, frozen while the oscillator is stopped
  // ****************************************************************
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (dv.run && dv.osc_rise)
    begin
      nxt_cnt = cnt_ff + otd_pkg::DIV_ONE;
    end
  end

  // taps registered so each output changes glitch-free
  genvar gi;
  generate
    for (gi = 0; gi < otd_pkg::TAP_N; gi++)
    begin : g_tap
      always_comb
      begin
        nxt_tap[gi] = cnt_ff[otd_pkg::TAP_BIT[gi]];
      end
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      cnt_ff <= otd_pkg::DIV_RST;
      tap_ff <= otd_pkg::TAP_RST;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tap_ff <= nxt_tap;
    end
  end

  assign dv.taps = tap_ff;

  property p_count_step;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (dv.run && dv.osc_rise) |=> (cnt_ff == $past(cnt_ff) + otd_pkg::DIV_ONE);
  endproperty
  a_count_step: assert property (p_count_step) else $error("divider missed a step");

  property p_tap_bits;
    @(posedge mclk_i) disable iff (!reset_n_i)
    1'b1 |=> (tap_ff == {$past(cnt_ff[otd_pkg::TAP_BIT[3]]),
                         $past(cnt_ff[otd_pkg::TAP_BIT[2]]),
                         $past(cnt_ff[otd_pkg::TAP_BIT[1]]),
                         $past(cnt_ff[otd_pkg::TAP_BIT[0]])});
  endproperty
  a_tap_bits: assert property (p_tap_bits) else $error("tap bit mismatch");
endmodule

// ==== logic/otd_oscillator_tap_divider.sv ====
// Behaviour
// - oscillator clocks power-on time-out, memory clearing, and master-mode configuration clock
// - oscillator runs at nominal 8 MHz, staying within 4 to 10 MHz
// - after configuration the undivided oscillator output is optionally given to user logic
// - four divider taps; any two selectable; each resynchronized before output
// - taps are divider bits three, eight, thirteen and eighteen
// - oscillator stops after configuration when the user design omits the oscillator
module otd_oscillator_tap_divider (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // configuration state
  input wire logic cfg_done_i,
  input wire logic cfg_master_i,
  input wire logic osc_used_i,
  // tap selection
  input wire logic [otd_pkg::SEL_W-1:0] tap_a_sel_i,
  input wire logic [otd_pkg::SEL_W-1:0] tap_b_sel_i,
  // configuration-time clocks
  output logic por_tick_o,
  output logic mem_clear_tick_o,
  output logic configuration_clock_o,
  // user clocks and oscillator status
  output logic osc_o,
  output logic tap_a_o,
  output logic tap_b_o,
  output logic osc_running_o
);
  otd_div_if dif ();

  logic [otd_pkg::PH_W-1:0] ph_ff;
  logic [otd_pkg::PH_W-1:0] nxt_ph;
  logic osc_ff;
  logic nxt_osc;
  logic run;
  logic rise;
  logic por_ff;
  logic nxt_por;
  logic clr_ff;
  logic nxt_clr;
  logic cfgclk_ff;
  logic nxt_cfgclk;
  logic uosc_ff;
  logic nxt_uosc;
  logic ta_ff;
  logic nxt_ta;
  logic tb_ff;
  logic nxt_tb;
  logic run_ff;
  logic [otd_pkg::PH_W-1:0] ph_sum;

  // ****************************************************************
  // oscillator model
  // ****************************************************************
  // the 8 MHz source is synthesised by a phase accumulator on the
  // 20 MHz clock, so edge spacing jitters between 1 and 2 cycles
  always_comb
  begin
    run = !cfg_done_i || osc_used_i;
    ph_sum = ph_ff + otd_pkg::PH_STEP;
    nxt_ph = ph_ff;
    nxt_osc = osc_ff;
    if (!run)
    begin
      nxt_ph = otd_pkg::PH_RST;
      nxt_osc = 1'b0;
    end
    else if (ph_sum >= otd_pkg::PH_WRAP)
    begin
      nxt_ph = ph_sum - otd_pkg::PH_WRAP;
      nxt_osc = !osc_ff;
    end
    else
    begin
      nxt_ph = ph_sum;
    end
    rise = run && !osc_ff && nxt_osc;
  end

  assign dif.run = run;
  assign dif.osc_rise = rise;

  otd_divider u_div (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .dv(dif.div)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb
  begin
    nxt_por = rise && !cfg_done_i;
    nxt_clr = rise && !cfg_done_i;
    nxt_cfgclk = cfg_master_i && !cfg_done_i && nxt_osc;
    nxt_uosc = cfg_done_i && osc_used_i && osc_ff;
    nxt_ta = cfg_done_i && osc_used_i && dif.taps[tap_a_sel_i];
    nxt_tb = cfg_done_i && osc_used_i && dif.taps[tap_b_sel_i];
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      ph_ff <= otd_pkg::PH_RST;
      osc_ff <= 1'b0;
      por_ff <= 1'b0;
      clr_ff <= 1'b0;
      cfgclk_ff <= 1'b0;
      uosc_ff <= 1'b0;
      ta_ff <= 1'b0;
      tb_ff <= 1'b0;
      run_ff <= 1'b0;
    end
    else
    begin
      ph_ff <= nxt_ph;
      osc_ff <= nxt_osc;
      por_ff <= nxt_por;
      clr_ff <= nxt_clr;
      cfgclk_ff <= nxt_cfgclk;
      uosc_ff <= nxt_uosc;
      ta_ff <= nxt_ta;
      tb_ff <= nxt_tb;
      run_ff <= run;
    end
  end

  assign por_tick_o = por_ff;
  assign mem_clear_tick_o = clr_ff;
  assign configuration_clock_o = cfgclk_ff;
  assign osc_o = uosc_ff;
  assign tap_a_o = ta_ff;
  assign tap_b_o = tb_ff;
  assign osc_running_o = run_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  // cycles since the oscillator last changed level; saturates so a stall
  // cannot wrap back into the legal band
  logic [3:0] gap_ff;
  logic [3:0] nxt_gap;
  always_comb
  begin
    nxt_gap = gap_ff;
    if (!run || (osc_ff != nxt_osc))
    begin
      nxt_gap = 4'h1;
    end
    else if (gap_ff != 4'hF)
    begin
      nxt_gap = gap_ff + 4'h1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      gap_ff <= 4'h1;
    end
    else
    begin
      gap_ff <= nxt_gap;
    end
  end

  property p_half_period;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (run && osc_ff != nxt_osc) |-> (gap_ff >= 4'(otd_pkg::HALF_MIN_CYC) &&
                                    gap_ff <= 4'(otd_pkg::HALF_MAX_CYC));
  endproperty
  a_half_period: assert property (p_half_period) else $error("oscillator out of band");

  sequence s_tick_start;
    rise && !cfg_done_i;
  endsequence
  sequence s_tick_pulse;
    (por_tick_o && mem_clear_tick_o) ##1 !por_tick_o;
  endsequence
  property p_por_tick;
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_tick_start |=> s_tick_pulse;
  endproperty
  a_por_tick: assert property (p_por_tick) else $error("config tick missing");

  property p_tick_pair;
    @(posedge mclk_i) disable iff (!reset_n_i)
    1'b1 |-> (por_tick_o == mem_clear_tick_o);
  endproperty
  a_tick_pair: assert property (p_tick_pair) else $error("tick outputs differ");

  property p_cfg_clock;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (cfg_master_i && !cfg_done_i) |=> (configuration_clock_o == $past(nxt_osc));
  endproperty
  a_cfg_clock: assert property (p_cfg_clock) else $error("configuration clock not from oscillator");

  property p_cfg_running;
    @(posedge mclk_i) disable iff (!reset_n_i)
    !cfg_done_i |=> osc_running_o;
  endproperty
  a_cfg_running: assert property (p_cfg_running) else $error("oscillator idle while configuring");

  property p_user_osc;
    @(posedge mclk_i) disable iff (!reset_n_i)
    !cfg_done_i |=> !osc_o && !tap_a_o && !tap_b_o;
  endproperty
  a_user_osc: assert property (p_user_osc) else $error("user clock before configuration");

  property p_osc_follow;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (cfg_done_i && osc_used_i) |=> (osc_o == $past(osc_ff));
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("user oscillator not passed on");

  property p_tap_resync;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (cfg_done_i && osc_used_i) |=> (tap_a_o == $past(dif.taps[tap_a_sel_i]) &&
                                   tap_b_o == $past(dif.taps[tap_b_sel_i]));
  endproperty
  a_tap_resync: assert property (p_tap_resync) else $error("tap select wrong");

  sequence s_unused;
    cfg_done_i && !osc_used_i;
  endsequence
  sequence s_stopped;
    !osc_running_o && !osc_ff;
  endsequence
  property p_auto_stop;
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_unused ##1 s_unused |-> s_stopped;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("oscillator left running");
endmodule

// ==== logic/otd_pkg.sv ====
package otd_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OSC_NOM_HZ = 8_000_000;
  localparam int unsigned OSC_MIN_HZ = 4_000_000;
  localparam int unsigned OSC_MAX_HZ = 10_000_000;
  localparam int unsigned PH_W = 25;
  // phase step per clock: two edges per oscillator period
  localparam logic [PH_W-1:0] PH_STEP = PH_W'(2 * OSC_NOM_HZ);
  localparam logic [PH_W-1:0] PH_WRAP = PH_W'(CLK_HZ);
  localparam logic [PH_W-1:0] PH_RST = 25'h0000000;
  // shortest half period (fast corner) rounds up, longest rounds down
  localparam int unsigned HALF_MIN_CYC = (CLK_HZ + 2 * OSC_MAX_HZ - 1) / (2 * OSC_MAX_HZ);
  localparam int unsigned HALF_MAX_CYC = CLK_HZ / (2 * OSC_MIN_HZ);
  // ****************************************************************
  // divider
  // ****************************************************************
  localparam int unsigned DIV_W = 19;
  localparam int unsigned TAP_N = 4;
  localparam int unsigned SEL_W = 2;
  localparam int unsigned TAP_BIT [TAP_N] = '{3, 8, 13, 18};
  localparam logic [DIV_W-1:0] DIV_RST = 19'h00000;
  localparam logic [DIV_W-1:0] DIV_ONE = 19'h00001;
  localparam logic [TAP_N-1:0] TAP_RST = 4'h0;
endpackage
